// File: src/dpm_core.sv
// The register addresses and the APB interface to the registers were left to the implementer.
module dpm_core (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ser_clk, // serial shift clock
  input wire logic ser_data, // serial data
  input wire logic ser_load, // serial latch enable
  input wire logic main_lock, // main loop lock indication
  input wire logic aux_lock, // aux loop lock indication
  input wire logic main_ref_div, // main reference divider output
  input wire logic aux_ref_div, // aux reference divider output
  input wire logic main_fb_div, // main feedback divider output
  input wire logic aux_fb_div, // aux feedback divider output
  input wire logic status_pin_in, // multifunction_status_pin level
  output logic status_pin_out, // pin drive value, always low
  output logic status_pin_oe_n, // low while pin pulled low
  output dpm_pkg::dpm_loop_ctl_t main_ctl, // main loop controls
  output dpm_pkg::dpm_loop_ctl_t aux_ctl, // aux loop controls
  output logic irq // level interrupt
);

  dpm_pkg::dpm_state_t st; // registered state
  dpm_pkg::dpm_state_t next_st; // next state

  // apb decode
  logic acc; // access phase of a transfer
  logic hit; // address maps a register
  logic [31:0] rd; // read mux

  assign acc = psel & penable;
  assign pready = acc;
  assign hit = (paddr == dpm_pkg::OFS_MODE) | (paddr == dpm_pkg::OFS_CTRL)
             | (paddr == dpm_pkg::OFS_IRQ_STAT) | (paddr == dpm_pkg::OFS_IRQ_MASK)
             | (paddr == dpm_pkg::OFS_LINK);
  assign pslverr = acc & ~hit;

  // read data mux over registered state
  always_comb begin
    rd = 32'h0;
    case (paddr)
      dpm_pkg::OFS_MODE: begin
        rd = {20'h0, st.main_pwdn, st.aux_pwdn, st.main_mode, st.aux_mode};
      end
      dpm_pkg::OFS_CTRL: begin
        rd = {30'h0, st.ctrl};
      end
      dpm_pkg::OFS_IRQ_STAT: begin
        rd = {29'h0, st.irq_stat};
      end
      dpm_pkg::OFS_IRQ_MASK: begin
        rd = {29'h0, st.irq_mask};
      end
      dpm_pkg::OFS_LINK: begin
        rd = {24'h0, st.sync2[dpm_pkg::SY_PIN], st.pin_low,
              st.main_ctl.counter_reset, st.aux_ctl.counter_reset,
              st.main_ctl.pump_high_impedance_bit, st.aux_ctl.pump_high_impedance_bit,
              st.sync2[dpm_pkg::SY_MLOCK], st.sync2[dpm_pkg::SY_ALOCK]};
      end
      default: begin
        rd = 32'h0; // unmapped reads as zero
      end
    endcase
  end

  assign prdata = (acc & ~pwrite) ? rd : 32'h0;

  // outputs from the state
  assign status_pin_out = 1'b0;
  assign status_pin_oe_n = ~st.pin_low;
  assign main_ctl = st.main_ctl;
  assign aux_ctl = st.aux_ctl;
  assign irq = |(st.irq_stat & st.irq_mask);

  // next state
  always_comb begin
    logic sclk_rise; // serial clock rising edge seen
    logic load_rise; // load rising edge seen
    logic [1:0] addr; // address of the shifted word
    logic [dpm_pkg::EV_W-1:0] ev; // events of this cycle
    logic [3:0] sel; // main18, aux18, main19, aux19
    logic m_rst; // main reset selection
    logic a_rst; // aux reset selection
    logic m_lk; // synced main lock
    logic a_lk; // synced aux lock
    sclk_rise = 1'b0;
    load_rise = 1'b0;
    addr = 2'h0;
    ev = '0;
    sel = 4'h0;
    m_rst = 1'b0;
    a_rst = 1'b0;
    m_lk = 1'b0;
    a_lk = 1'b0;
    next_st = st;

    // two stage synchroniser of every outside input
    next_st.sync1 = {status_pin_in, aux_fb_div, main_fb_div, aux_ref_div, main_ref_div,
                     aux_lock, main_lock, ser_load, ser_data, ser_clk};
    next_st.sync2 = st.sync1;

    // edge detection on the second stage only
    next_st.sclk_prev = st.sync2[dpm_pkg::SY_SCLK];
    next_st.load_prev = st.sync2[dpm_pkg::SY_LOAD];
    sclk_rise = st.sync2[dpm_pkg::SY_SCLK] & ~st.sclk_prev;
    load_rise = st.sync2[dpm_pkg::SY_LOAD] & ~st.load_prev;
    m_lk = st.sync2[dpm_pkg::SY_MLOCK];
    a_lk = st.sync2[dpm_pkg::SY_ALOCK];
    next_st.lock_prev = {m_lk, a_lk};

    // shift on each serial clock rising edge, first bit ends at the top
    if (sclk_rise) begin
      next_st.shift = {st.shift[dpm_pkg::WORD_W-2:0], st.sync2[dpm_pkg::SY_SDATA]};
    end

    // latch at load; power-down state does not block it
    addr = st.shift[dpm_pkg::ADDR_W-1:0];
    if (load_rise && st.ctrl[dpm_pkg::CTRL_LOAD_EN]) begin
      ev[dpm_pkg::EV_LOADED] = 1'b1;
      case (addr)
        dpm_pkg::ADDR_AUX_REF: begin
          next_st.aux_mode = st.shift[dpm_pkg::MODE_LSB +: dpm_pkg::MODE_W];
        end
        dpm_pkg::ADDR_MAIN_REF: begin
          next_st.main_mode = st.shift[dpm_pkg::MODE_LSB +: dpm_pkg::MODE_W];
        end
        dpm_pkg::ADDR_AUX_FB: begin
          next_st.aux_pwdn = st.shift[dpm_pkg::PWDN_POS];
        end
        default: begin
          next_st.main_pwdn = st.shift[dpm_pkg::PWDN_POS];
        end
      endcase
    end

    // status pin selection from the latched modes
    sel = {st.main_mode[dpm_pkg::SEL0_BIT], st.aux_mode[dpm_pkg::SEL0_BIT],
           st.main_mode[dpm_pkg::SEL1_BIT], st.aux_mode[dpm_pkg::SEL1_BIT]};
    next_st.pin_low = 1'b0; // released by default
    case (sel)
      4'h0: begin
        next_st.pin_low = 1'b0; // disabled
      end
      4'h4: begin
        next_st.pin_low = ~a_lk;
      end
      4'h8: begin
        next_st.pin_low = ~m_lk;
      end
      4'hc: begin
        next_st.pin_low = ~(m_lk & a_lk);
      end
      4'h1, 4'h9: begin
        next_st.pin_low = ~st.sync2[dpm_pkg::SY_AREF];
      end
      4'h2, 4'ha: begin
        next_st.pin_low = ~st.sync2[dpm_pkg::SY_MREF];
      end
      4'h5, 4'hd: begin
        next_st.pin_low = ~st.sync2[dpm_pkg::SY_AFB];
      end
      4'h6, 4'he: begin
        next_st.pin_low = ~st.sync2[dpm_pkg::SY_MFB];
      end
      4'h3: begin
        next_st.pin_low = st.main_mode[dpm_pkg::GAIN_BIT];
      end
      4'h7: begin
        a_rst = 1'b1;
      end
      4'hb: begin
        m_rst = 1'b1;
      end
      4'hf: begin
        a_rst = 1'b1;
        m_rst = 1'b1;
      end
      default: begin
        next_st.pin_low = 1'b0;
      end
    endcase
    // software may force the pin released
    if (st.ctrl[dpm_pkg::CTRL_PIN_OFF]) begin
      next_st.pin_low = 1'b0;
    end

    // loop controls; both counters of a loop share one reset so they restart together
    next_st.main_ctl.pump_high_impedance_bit = st.main_mode[dpm_pkg::HIZ_BIT] | m_rst;
    next_st.aux_ctl.pump_high_impedance_bit = st.aux_mode[dpm_pkg::HIZ_BIT] | a_rst;
    next_st.main_ctl.pump_current_gain_bit = st.main_mode[dpm_pkg::GAIN_BIT];
    next_st.aux_ctl.pump_current_gain_bit = st.aux_mode[dpm_pkg::GAIN_BIT];
    next_st.main_ctl.detector_polarity_bit = st.main_mode[dpm_pkg::POL_BIT];
    next_st.aux_ctl.detector_polarity_bit = st.aux_mode[dpm_pkg::POL_BIT];
    next_st.main_ctl.counter_reset = m_rst | st.main_pwdn;
    next_st.aux_ctl.counter_reset = a_rst | st.aux_pwdn;

    // lock loss events
    ev[dpm_pkg::EV_MAIN_LOST] = st.lock_prev[1] & ~m_lk;
    ev[dpm_pkg::EV_AUX_LOST] = st.lock_prev[0] & ~a_lk;

    // apb writes and read-clear; a new event wins over the clear
    if (acc && pwrite && paddr == dpm_pkg::OFS_CTRL) begin
      next_st.ctrl = pwdata[1:0];
    end
    if (acc && pwrite && paddr == dpm_pkg::OFS_IRQ_MASK) begin
      next_st.irq_mask = pwdata[dpm_pkg::EV_W-1:0];
    end
    if (acc && !pwrite && paddr == dpm_pkg::OFS_IRQ_STAT) begin
      next_st.irq_stat = ev;
    end else begin
      next_st.irq_stat = st.irq_stat | ev;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= dpm_pkg::CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

endmodule

// File: src/dpm_pkg.sv
// shared constants and carriers of the dual loop mode and status block
package dpm_pkg;

  // serial word: 20 data bits above 2 address bits
  localparam int WORD_W = 22;
  localparam int ADDR_W = 2;
  localparam int MODE_LSB = 17; // word bit 15 sits at shift bit 17
  localparam int MODE_W = 5;
  localparam int PWDN_POS = 21; // word bit 19 of a feedback word

  // address codes of the serial words
  localparam logic [1:0] ADDR_AUX_REF = 2'h0;
  localparam logic [1:0] ADDR_AUX_FB = 2'h1;
  localparam logic [1:0] ADDR_MAIN_REF = 2'h2;
  localparam logic [1:0] ADDR_MAIN_FB = 2'h3;

  // field positions inside a loop's mode bits
  localparam int POL_BIT = 0;
  localparam int GAIN_BIT = 1;
  localparam int HIZ_BIT = 2;
  localparam int SEL0_BIT = 3;
  localparam int SEL1_BIT = 4;

  // synchroniser lane positions
  localparam int SY_SCLK = 0;
  localparam int SY_SDATA = 1;
  localparam int SY_LOAD = 2;
  localparam int SY_MLOCK = 3;
  localparam int SY_ALOCK = 4;
  localparam int SY_MREF = 5;
  localparam int SY_AREF = 6;
  localparam int SY_MFB = 7;
  localparam int SY_AFB = 8;
  localparam int SY_PIN = 9;
  localparam int SY_W = 10;

  // apb register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_LINK = 8'h10;

  // control register bits and reset value
  localparam int CTRL_LOAD_EN = 0;
  localparam int CTRL_PIN_OFF = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // interrupt events
  localparam int EV_LOADED = 0;
  localparam int EV_MAIN_LOST = 1;
  localparam int EV_AUX_LOST = 2;
  localparam int EV_W = 3;

  // per loop controls toward the analog side
  typedef struct packed {
    logic pump_high_impedance_bit; // pump output released
    logic pump_current_gain_bit; // 1 high level, 0 quarter level
    logic detector_polarity_bit; // detector sense
    logic counter_reset; // hold reference and feedback counters
  } dpm_loop_ctl_t;

  // all state of the core
  typedef struct packed {
    logic [SY_W-1:0] sync1; // first synchroniser stage
    logic [SY_W-1:0] sync2; // second synchroniser stage
    logic sclk_prev; // previous serial clock level
    logic load_prev; // previous load level
    logic [1:0] lock_prev; // previous lock levels, main then aux
    logic [WORD_W-1:0] shift; // serial shift register
    logic [MODE_W-1:0] main_mode; // latched main mode bits
    logic [MODE_W-1:0] aux_mode; // latched aux mode bits
    logic main_pwdn; // main loop powered down
    logic aux_pwdn; // aux loop powered down
    logic [1:0] ctrl; // software control bits
    logic [EV_W-1:0] irq_stat; // sticky events
    logic [EV_W-1:0] irq_mask; // event enables
    logic pin_low; // status pin pulled low
    dpm_loop_ctl_t main_ctl; // main loop controls
    dpm_loop_ctl_t aux_ctl; // aux loop controls
  } dpm_state_t;

endpackage

// File: verif/dpm_core_properties.sv
// port level checks of the mode and status block
module dpm_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low active
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic ser_load, // latch strobe
  input wire logic main_lock, // main lock
  input wire logic status_pin_out, // pin value
  input wire dpm_pkg::dpm_loop_ctl_t main_ctl, // main controls
  input wire dpm_pkg::dpm_loop_ctl_t aux_ctl, // aux controls
  input wire logic irq // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait state answer
  property p_ready; pready == (psel && penable); endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  // outputs quiet outside the access phase
  property p_idle; !(psel && penable) |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("bus not quiet");
  // unmapped places refused
  property p_err; psel && penable && paddr > 8'h10 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_ok; psel && penable && paddr <= 8'h10 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false slverr");
  // open drain: only ever pulls low
  property p_pin; status_pin_out == 1'b0; endproperty
  a_pin: assert property (p_pin) else $error("pin driven high");
  // controls move only after a latch strobe
  property p_hold; (!ser_load)[*8] |=> $stable(main_ctl) && $stable(aux_ctl); endproperty
  a_hold: assert property (p_hold) else $error("controls moved");
  // interrupt drops only by a bus access
  property p_irq; $fell(irq) |-> $past(psel && penable); endproperty
  a_irq: assert property (p_irq) else $error("irq fell alone");
  // lock level seen through the link register
  property p_link;
    ($stable(main_lock)[*5] ##0 (psel && penable && !pwrite && paddr == 8'h10))
      |-> prdata[1] == main_lock;
  endproperty
  a_link: assert property (p_link) else $error("link lock wrong");
endmodule

bind dpm_core dpm_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .ser_load, .main_lock, .status_pin_out, .main_ctl, .aux_ctl, .irq);

// File: verif/dpm_host.sv
// baseband host: three wire serial loader
module dpm_host (
  input wire logic pclk, // system clock
  output logic ser_clk, // shift clock, idle low
  output logic ser_data, // serial data
  output logic ser_load // latch strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end
  // half of the 160 ns link period
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask
  // one word, msb first, data set before each rising edge
  task automatic send(input logic [21:0] w);
    for (int i = 21; i >= 0; i--) begin
      ser_data <= w[i];
      half();
      ser_clk <= 1'b1;
      half();
      ser_clk <= 1'b0;
    end
    ser_data <= ~w[0]; // line driven to the inverse of the last bit shows no stale bit
    half();
    ser_load <= 1'b1;
    half();
    ser_load <= 1'b0;
    half();
  endtask
endmodule

// File: verif/dpm_core_tb.sv
// self checking bench of the mode and status block
module dpm_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ser_clk, ser_data, ser_load, pin_out, oe_n, irq, err;
  logic [5:0] ins = 6'h00; // mlock alock mref aref mfb afb
  dpm_pkg::dpm_loop_ctl_t main_ctl, aux_ctl;
  int n_errors = 0, samples_checked = 0;
  always #10 pclk = ~pclk;
  // pin has a pull-up: level is the enable itself
  dpm_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ser_clk, .ser_data, .ser_load, .main_lock(ins[5]), .aux_lock(ins[4]),
    .main_ref_div(ins[3]), .aux_ref_div(ins[2]), .main_fb_div(ins[1]), .aux_fb_div(ins[0]),
    .status_pin_in(oe_n), .status_pin_out(pin_out), .status_pin_oe_n(oe_n), .main_ctl,
    .aux_ctl, .irq);
  dpm_host host (.pclk, .ser_clk, .ser_data, .ser_load);
  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++t > 50) begin
        n_errors++;
        end_sim();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge pclk);
  endtask
  // expected pin enable for selection k and inputs p
  function automatic logic pin_exp(input logic [4:0] k, input logic [5:0] p);
    casez (k[4:1])
      4'b0000: return 1'b1;
      4'b0100: return p[4];
      4'b1000: return p[5];
      4'b1100: return p[5] & p[4];
      4'b?001: return p[2];
      4'b?010: return p[3];
      4'b?101: return p[0];
      4'b?110: return p[1];
      4'b0011: return !k[0];
      default: return 1'b1;
    endcase
  endfunction
  task automatic s_regs();
    rdchk("ctrl", 8'h04, 32'h1);
    rdchk("mode", 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h5);
    rdchk("mask", 8'h0c, 32'h5);
    apb(1'b1, 8'h14, 32'h1);
    chk("slverr", 32'h1, {31'h0, err});
    rdchk("link", 8'h10, 32'h80);
  endtask
  task automatic s_modes();
    for (int i = 0; i < 8; i++) begin
      host.send({2'b00, i[2:0], 15'h0003, 2'h2});
      host.send({2'b00, ~i[2:0], 15'h0003, 2'h0});
      chk("main_ctl", {28'h0, i[2:0], 1'b0}, {28'h0, main_ctl});
      chk("aux_ctl", {28'h0, ~i[2:0], 1'b0}, {28'h0, aux_ctl});
      chk("pin", 32'h1, {31'h0, oe_n});
      rdchk("mode", 8'h00, {22'h0, 2'b00, i[2:0], 2'b00, ~i[2:0]});
    end
  endtask
  task automatic s_pin();
    logic [4:0] k;
    logic [5:0] pat [3] = '{6'h29, 6'h16, 6'h36};
    logic rm, ra;
    for (int c = 0; c < 32; c++) begin
      k = c[4:0];
      rm = k[4] & k[2] & k[1];
      ra = k[3] & k[2] & k[1];
      host.send({k[2], k[4], 1'b0, k[0], 1'b0, 15'h0003, 2'h2});
      host.send({k[1], k[3], 3'b000, 15'h0003, 2'h0});
      chk("main_ctl", {28'h0, rm, k[0], 1'b0, rm}, {28'h0, main_ctl});
      chk("aux_ctl", {28'h0, ra, 2'b00, ra}, {28'h0, aux_ctl});
      foreach (pat[j]) begin
        ins <= pat[j];
        repeat (6) @(posedge pclk);
        chk("pin", {31'h0, pin_exp(k, pat[j])}, {31'h0, oe_n});
      end
    end
  endtask
  task automatic s_pwr();
    host.send({1'b1, 19'h0, 2'h3});
    host.send({2'b00, 3'b010, 15'h0003, 2'h2});
    chk("main_ctl", 32'h5, {28'h0, main_ctl});
    rdchk("mode", 8'h00, 32'h858);
    host.send({20'h0, 2'h3});
    chk("main_ctl", 32'h4, {28'h0, main_ctl});
  endtask
  task automatic s_irq();
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk_irq(1'b0);
    host.send({2'b00, 3'b010, 15'h0003, 2'h2});
    chk_irq(1'b1);
    rdchk("stat", 8'h08, 32'h1);
    chk_irq(1'b0);
    apb(1'b1, 8'h0c, 32'h2);
    ins <= 6'h30;
    repeat (6) @(posedge pclk);
    ins <= 6'h10;
    repeat (6) @(posedge pclk);
    chk_irq(1'b1);
    ins <= 6'h00;
    repeat (6) @(posedge pclk);
    rdchk("stat", 8'h08, 32'h6);
  endtask
  task automatic s_ldoff();
    dpm_pkg::dpm_loop_ctl_t keep;
    keep = main_ctl;
    apb(1'b1, 8'h04, 32'h0);
    host.send({2'b00, 3'b111, 15'h0003, 2'h2});
    chk("main_ctl", {28'h0, keep}, {28'h0, main_ctl});
    apb(1'b1, 8'h04, 32'h1);
    // aux feedback selection with a low divider input pulls the pin low
    chk("pin", 32'h0, {31'h0, oe_n});
    apb(1'b1, 8'h04, 32'h3);
    repeat (2) @(posedge pclk);
    chk("pin_off", 32'h1, {31'h0, oe_n});
    apb(1'b1, 8'h04, 32'h1);
    repeat (2) @(posedge pclk);
    chk("pin", 32'h0, {31'h0, oe_n});
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_modes();
    s_pin();
    s_pwr();
    s_irq();
    s_ldoff();
    end_sim();
  end
endmodule
